// file: pkg/wtw_pkg.sv
// Constants and types for the wheel touch and wake logic
// Summary of operation
// - Wheel has 256 segments; position zero shifts by the programmed offset.
// - Count scans with ticks below negative threshold; start compensation on reaching the maximum.
// - Hold averaging filters while ticks reach or exceed the average threshold.
// - Three or more sensors at average threshold start offset compensation.
// - Rotation status set only when position step exceeds rotation threshold.
// - Debounce touch with config bits [1:0], release with bits [3:2].
// - Wheel touched when pressure is greater than the press margin.
// - Stuck timeout forces release until real release; zero disables it.
// - Wake length: 0 any event, 1..6 key sequence, 7 no sensor wake.
// - Each wake key validated on release; other events meanwhile ignored.
// - Key selector: 0..11 buttons, 12 touch, 13 ccw, 14 cw, 15 reserved.
// - Upper nibble of first autolight map selects event driving output 7.
// - Offset added clockwise, offset/256 of a full turn.
// - Wheel released when pressure equals zero, after the release debounce, or by the stuck timeout.
// - Rotation threshold is a percentage of maximum position, default 2.
// - Maximum position is position scale divided by 32 times sensor count.
package wtw_pkg;

  localparam int NUM_SENSORS = 6;
  localparam int NUM_BUTTONS = 12;
  localparam int SEGMENTS = 256;
  localparam int NORM_DIV = 32;
  localparam int MAX_KEYS = 6;
  localparam int AVG_COMP_MIN = 3;

  localparam logic [7:0] ADDR_WAKE_LEN = 8'h33;
  localparam logic [7:0] ADDR_WAKE_KEY_HI = 8'h34;
  localparam logic [7:0] ADDR_WAKE_KEY_MID = 8'h35;
  localparam logic [7:0] ADDR_WAKE_KEY_LO = 8'h36;
  localparam logic [7:0] ADDR_LED_MAP = 8'h37;

  localparam logic [7:0] RST_WAKE_LEN = 8'h00;
  localparam logic [7:0] RST_WAKE_KEY = 8'h00;
  localparam logic [7:0] RST_LED_MAP = 8'h00;

  localparam int WAKE_LEN_LSB = 0;
  localparam int WAKE_LEN_W = 3;
  localparam int LED7_SEL_LSB = 4;
  localparam int DEB_TOUCH_LSB = 0;
  localparam int DEB_REL_LSB = 2;

  localparam logic [2:0] WAKE_ANY = 3'h0;
  localparam logic [2:0] WAKE_NONE = 3'h7;

  localparam logic [3:0] SEL_TOUCH = 4'hc;
  localparam logic [3:0] SEL_CCW = 4'hd;
  localparam logic [3:0] SEL_CW = 4'he;
  localparam logic [3:0] SEL_BTN_LAST = 4'hb;

  localparam logic [3:0] LED_SEL_GRP0 = 4'hc;
  localparam logic [3:0] LED_SEL_GRP1 = 4'hd;
  localparam logic [3:0] LED_SEL_CCW = 4'he;
  localparam logic [3:0] LED_SEL_CW = 4'hf;

  localparam logic [7:0] RST_TURN_LIMIT = 8'h02;
  localparam logic [15:0] RST_POS_SCALE = 16'h0140;

  typedef struct packed {
    logic [11:0] buttons;
    logic touch;
    logic ccw;
    logic cw;
  } wtw_events_t;

  typedef struct packed {
    logic [7:0] wheel_angle_shift;
    logic [7:0] turn_detect_limit;
    logic [3:0] wheel_debounce_config;
    logic [15:0] press_margin;
    logic [15:0] hold_release_timeout;
    logic [15:0] position_scale;
  } wtw_cfg_t;

endpackage : wtw_pkg

// file: hdl/wtw_core.sv
// Wheel post-processing, wake sequence and register file
`timescale 1ns/1ps
module wtw_core
  import wtw_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic scan_valid,
  input wire logic [15:0] raw_position,
  input wire logic [15:0] pressure,
  input wire logic [NUM_SENSORS*10-1:0] wheel_ticks,
  input wire logic [9:0] filter_freeze_level,
  input wire logic [9:0] low_tick_limit,
  input wire logic [7:0] low_tick_count_limit,
  input wire logic [11:0] buttons,
  input wire logic doze,
  input wire logic general_input,
  input wire logic wake_cmd,
  input wire wtw_cfg_t cfg,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic [15:0] wheel_position,
  output logic wheel_touched,
  output logic rotate_cw,
  output logic rotate_ccw,
  output logic filter_hold,
  output logic comp_start,
  output logic wake,
  output logic led7_on
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] wake_len_q, key_hi_q, key_mid_q, key_lo_q, led_map_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wake_len_q <= RST_WAKE_LEN;
      key_hi_q <= RST_WAKE_KEY;
      key_mid_q <= RST_WAKE_KEY;
      key_lo_q <= RST_WAKE_KEY;
      led_map_q <= RST_LED_MAP;
    end else if (reg_wr) begin
      unique case (reg_addr)
        ADDR_WAKE_LEN: wake_len_q <= reg_wdata & 8'h07;
        ADDR_WAKE_KEY_HI: key_hi_q <= reg_wdata;
        ADDR_WAKE_KEY_MID: key_mid_q <= reg_wdata;
        ADDR_WAKE_KEY_LO: key_lo_q <= reg_wdata;
        ADDR_LED_MAP: led_map_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    unique case (reg_addr)
      ADDR_WAKE_LEN: reg_rdata = wake_len_q;
      ADDR_WAKE_KEY_HI: reg_rdata = key_hi_q;
      ADDR_WAKE_KEY_MID: reg_rdata = key_mid_q;
      ADDR_WAKE_KEY_LO: reg_rdata = key_lo_q;
      ADDR_LED_MAP: reg_rdata = led_map_q;
      default: reg_rdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Position offset and rotation
  // ----------------------------------------------------------------
  logic [31:0] pos_max, shift_amt, pos_sum, pos_wrapped, turn_lim;
  logic [15:0] prev_pos_q;
  logic [31:0] step_fwd, step_back;
  logic first_q;

  // Max position from scale and sensor count
  assign pos_max = (32'(cfg.position_scale) / NORM_DIV) * NUM_SENSORS;
  // Clockwise shift of offset/256 turn
  assign shift_amt = (pos_max * 32'(cfg.wheel_angle_shift)) / SEGMENTS;
  assign pos_sum = 32'(raw_position) + shift_amt;
  // Wrap into range
  assign pos_wrapped = (pos_max == 32'h0) ? pos_sum : pos_sum % pos_max;
  // Threshold as a percentage of max
  assign turn_lim = (pos_max * 32'(cfg.turn_detect_limit)) / 100;
  assign step_fwd = (pos_wrapped + pos_max - 32'(prev_pos_q))
                    % ((pos_max == 32'h0) ? 32'h1 : pos_max);
  assign step_back = (32'(prev_pos_q) + pos_max - pos_wrapped)
                     % ((pos_max == 32'h0) ? 32'h1 : pos_max);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wheel_position <= 16'h0000;
      prev_pos_q <= 16'h0000;
      first_q <= 1'b1;
      rotate_cw <= 1'b0;
      rotate_ccw <= 1'b0;
    end else if (scan_valid) begin
      wheel_position <= pos_wrapped[15:0];
      prev_pos_q <= pos_wrapped[15:0];
      first_q <= ~wheel_touched;
      // Shorter way round decides direction
      rotate_cw <= wheel_touched && !first_q && step_fwd <= step_back
                   && step_fwd > turn_lim;
      rotate_ccw <= wheel_touched && !first_q && step_back < step_fwd
                    && step_back > turn_lim;
    end
  end

  // ----------------------------------------------------------------
  // Filter hold and compensation triggers
  // ----------------------------------------------------------------
  logic [2:0] above_cnt;
  logic any_above, any_below;
  logic [7:0] neg_cnt_q;

  always_comb begin
    above_cnt = 3'h0;
    any_below = 1'b0;
    for (int i = 0; i < NUM_SENSORS; i++) begin
      if (!wheel_ticks[i*10+9] && wheel_ticks[i*10 +: 10] >= filter_freeze_level)
        above_cnt = above_cnt + 3'h1;
      if (wheel_ticks[i*10+9] && (10'(-wheel_ticks[i*10 +: 10]) > low_tick_limit))
        any_below = 1'b1;
    end
  end
  assign any_above = above_cnt != 3'h0;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      filter_hold <= 1'b0;
      neg_cnt_q <= 8'h00;
      comp_start <= 1'b0;
    end else begin
      comp_start <= 1'b0;
      if (scan_valid) begin
        filter_hold <= any_above;
        if (above_cnt >= 3'(AVG_COMP_MIN)) begin
          comp_start <= 1'b1;
          neg_cnt_q <= 8'h00;
        end else if (any_below) begin
          // Limit of 1 fires on first low scan
          if (neg_cnt_q + 8'h01 >= low_tick_count_limit) begin
            comp_start <= 1'b1;
            neg_cnt_q <= 8'h00;
          end else begin
            neg_cnt_q <= neg_cnt_q + 8'h01;
          end
        end else begin
          neg_cnt_q <= 8'h00;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Touch debounce and stuck timeout
  // ----------------------------------------------------------------
  logic [1:0] deb_q;
  logic [15:0] hold_cnt_q;
  logic stuck_q;
  logic raw_touch, raw_rel;

  assign raw_touch = pressure > cfg.press_margin;
  assign raw_rel = pressure == 16'h0000;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wheel_touched <= 1'b0;
      deb_q <= 2'h0;
      hold_cnt_q <= 16'h0000;
      stuck_q <= 1'b0;
    end else if (scan_valid) begin
      if (!wheel_touched) begin
        if (raw_touch && !stuck_q) begin
          if (deb_q >= cfg.wheel_debounce_config[DEB_TOUCH_LSB +: 2]) begin
            wheel_touched <= 1'b1;
            deb_q <= 2'h0;
            hold_cnt_q <= 16'h0000;
          end else begin
            deb_q <= deb_q + 2'h1;
          end
        end else begin
          deb_q <= 2'h0;
        end
        if (raw_rel) stuck_q <= 1'b0;
      end else if (raw_rel) begin
        if (deb_q >= cfg.wheel_debounce_config[DEB_REL_LSB +: 2]) begin
          wheel_touched <= 1'b0;
          deb_q <= 2'h0;
          stuck_q <= 1'b0;
        end else begin
          deb_q <= deb_q + 2'h1;
        end
      end else begin
        deb_q <= 2'h0;
        if (cfg.hold_release_timeout != 16'h0000) begin
          if (hold_cnt_q + 16'h0001 >= cfg.hold_release_timeout) begin
            wheel_touched <= 1'b0;
            stuck_q <= 1'b1;
          end else begin
            hold_cnt_q <= hold_cnt_q + 16'h0001;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Event selection and wake sequence
  // ----------------------------------------------------------------
  wtw_events_t ev;
  assign ev = '{buttons: buttons, touch: wheel_touched,
                ccw: rotate_ccw, cw: rotate_cw};

  function automatic logic sel_event(input logic [3:0] sel,
                                     input wtw_events_t e);
    logic r;
    r = 1'b0;
    if (sel <= SEL_BTN_LAST) r = e.buttons[sel];
    else if (sel == SEL_TOUCH) r = e.touch;
    else if (sel == SEL_CCW) r = e.ccw;
    else if (sel == SEL_CW) r = e.cw;
    return r;
  endfunction

  logic [3:0] led7_sel;
  assign led7_sel = led_map_q[LED7_SEL_LSB +: 4];

  // Autolight codes differ from wake codes; group events read as off
  always_comb begin
    unique case (led7_sel)
      LED_SEL_CCW: led7_on = rotate_ccw;
      LED_SEL_CW: led7_on = rotate_cw;
      LED_SEL_GRP0, LED_SEL_GRP1: led7_on = 1'b0;
      default: led7_on = buttons[led7_sel];
    endcase
  end

  logic [23:0] keys;
  logic [2:0] key_idx_q;
  logic pressed_q;
  logic [3:0] cur_sel;
  logic cur_ev, any_ev;

  assign keys = {key_hi_q, key_mid_q, key_lo_q};
  assign cur_sel = keys[4*key_idx_q +: 4];
  assign cur_ev = sel_event(cur_sel, ev);
  assign any_ev = (|buttons) | wheel_touched | rotate_cw | rotate_ccw;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wake <= 1'b0;
      key_idx_q <= 3'h0;
      pressed_q <= 1'b0;
    end else begin
      wake <= 1'b0;
      if (!doze) begin
        key_idx_q <= 3'h0;
        pressed_q <= 1'b0;
      end else if (general_input || wake_cmd) begin
        wake <= 1'b1;
      end else begin
        unique case (wake_len_q[WAKE_LEN_LSB +: WAKE_LEN_W])
          WAKE_ANY: wake <= any_ev;
          WAKE_NONE: ;
          default: begin
            // Other events while pressed are ignored
            if (!pressed_q) begin
              if (cur_ev) pressed_q <= 1'b1;
            end else if (!cur_ev) begin
              pressed_q <= 1'b0;
              if (key_idx_q + 3'h1 >= wake_len_q[2:0]) begin
                wake <= 1'b1;
                key_idx_q <= 3'h0;
              end else begin
                key_idx_q <= key_idx_q + 3'h1;
              end
            end
          end
        endcase
      end
    end
  end

endmodule // wtw_core

// file: tb/wtw_host_model.sv
// Host-side register access model
`timescale 1ns/1ps
module wtw_host (
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic [7:0] low_tick_count_limit
);
  initial begin
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  assign low_tick_count_limit = 8'h01;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    @(posedge clk);
    #1 d = reg_rdata;
  endtask
endmodule // wtw_host

// file: tb/wtw_core_checker.sv
// Concurrent assertions on the wheel touch and wake ports
`timescale 1ns/1ps
module wtw_core_checker
  import wtw_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic scan_valid,
  input wire logic [15:0] raw_position,
  input wire logic [15:0] pressure,
  input wire logic [NUM_SENSORS*10-1:0] wheel_ticks,
  input wire logic [9:0] filter_freeze_level,
  input wire logic doze,
  input wire logic wake_cmd,
  input wire wtw_cfg_t cfg,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [15:0] wheel_position,
  input wire logic wheel_touched,
  input wire logic rotate_cw,
  input wire logic rotate_ccw,
  input wire logic filter_hold,
  input wire logic comp_start,
  input wire logic wake
);
  int n_ge;
  logic any_gt;
  always_comb begin
    n_ge = 0;
    any_gt = 1'b0;
    for (int i = 0; i < NUM_SENSORS; i++) begin
      if ($signed(wheel_ticks[i*10+:10]) >=
          $signed({1'b0, filter_freeze_level})) n_ge++;
      if ($signed(wheel_ticks[i*10+:10]) >
          $signed({1'b0, filter_freeze_level})) any_gt = 1'b1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence wr_hi_s; reg_wr && reg_addr == ADDR_WAKE_KEY_HI; endsequence
  sequence rd_hi_s; reg_addr == ADDR_WAKE_KEY_HI; endsequence
  key_echo_a: assert property (wr_hi_s ##1 rd_hi_s |->
    reg_rdata == $past(reg_wdata)) else $error("key readback wrong");
  pos_pass_a: assert property (scan_valid && cfg.wheel_angle_shift == 0
    && raw_position < (cfg.position_scale / NORM_DIV) * NUM_SENSORS
    |=> wheel_position == $past(raw_position))
    else $error("position changed with zero shift");
  no_touch_a: assert property (scan_valid && pressure <= cfg.press_margin
    && !wheel_touched |=> !wheel_touched) else $error("touch too early");
  zero_rel_a: assert property (scan_valid && pressure == 0 &&
    cfg.wheel_debounce_config[3:2] == 2'b00 |=> !wheel_touched)
    else $error("no release at zero pressure");
  turn_scan_a: assert property ($rose(rotate_cw) || $rose(rotate_ccw)
    |-> $past(scan_valid) && !(rotate_cw && rotate_ccw))
    else $error("rotation off scan");
  comp_pulse_a: assert property (comp_start |-> $past(scan_valid)
    ##1 !comp_start) else $error("compensation pulse wrong");
  avg_comp_a: assert property (scan_valid && n_ge >= AVG_COMP_MIN
    |=> comp_start) else $error("no compensation on wide touch");
  hold_filt_a: assert property (scan_valid && any_gt |=> filter_hold)
    else $error("filter not held");
  cmd_wake_a: assert property ($rose(wake_cmd) && doze |->
    ##[1:2] wake) else $error("no wake on command");
  awake_idle_a: assert property (!doze |=> !wake)
    else $error("wake outside doze");
endmodule // wtw_core_checker
bind wtw_core wtw_core_checker u_chk (.clk(clk), .reset(reset),
  .scan_valid(scan_valid), .raw_position(raw_position),
  .pressure(pressure), .wheel_ticks(wheel_ticks),
  .filter_freeze_level(filter_freeze_level), .doze(doze),
  .wake_cmd(wake_cmd), .cfg(cfg), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .wheel_position(wheel_position), .wheel_touched(wheel_touched),
  .rotate_cw(rotate_cw), .rotate_ccw(rotate_ccw),
  .filter_hold(filter_hold), .comp_start(comp_start), .wake(wake));

// file: tb/tb.sv
// Self-checking testbench for the wheel touch and wake logic
`timescale 1ns/1ps
module tb;
  import wtw_pkg::*;
  logic clk = 0, reset = 1, scan_valid = 0, doze = 0, wake_cmd = 0;
  logic gen_in = 0;
  logic [15:0] raw_position = 0, pressure = 0, wheel_position;
  logic [59:0] wheel_ticks = 0;
  logic [11:0] buttons = 0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, low_tick_count_limit, rd;
  logic reg_wr, cs, wheel_touched, rotate_cw, rotate_ccw;
  logic filter_hold, comp_start, wake, led7_on;
  wtw_cfg_t cfg = '0;
  int err_total = 0, num_checks = 0, wake_cnt = 0, w0;
  always #5 clk = ~clk;
  always @(posedge clk) if (wake) wake_cnt++;
  wtw_host u_host (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .low_tick_count_limit(low_tick_count_limit));
  wtw_core u_dut (.clk(clk), .reset(reset), .scan_valid(scan_valid),
    .raw_position(raw_position), .pressure(pressure),
    .wheel_ticks(wheel_ticks), .filter_freeze_level(10'h140),
    .low_tick_limit(10'h064), .low_tick_count_limit(low_tick_count_limit),
    .buttons(buttons), .doze(doze), .general_input(gen_in),
    .wake_cmd(wake_cmd), .cfg(cfg), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .wheel_position(wheel_position), .wheel_touched(wheel_touched),
    .rotate_cw(rotate_cw), .rotate_ccw(rotate_ccw),
    .filter_hold(filter_hold), .comp_start(comp_start), .wake(wake),
    .led7_on(led7_on));
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] ex);
    num_checks++;
    if (seen !== ex) begin
      err_total++;
      $display("CHECK FAILED %s exp %h seen %h", nm, ex, seen);
    end
  endtask
  task scan(input logic [15:0] pos, input logic [15:0] pres);
    @(posedge clk);
    scan_valid <= 1'b1;
    raw_position <= pos;
    pressure <= pres;
    @(posedge clk);
    scan_valid <= 1'b0;
    #1 cs = comp_start;
  endtask
  task wk(input logic [11:0] b);
    @(posedge clk);
    buttons <= b;
    repeat (3) @(posedge clk);
  endtask
  task summarize;
    if (err_total == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #300000;
    err_total++;
    summarize;
  end
  initial begin
    cfg.press_margin = 16'd100;
    cfg.position_scale = 16'h0140;
    cfg.turn_detect_limit = 8'h02;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    for (int a = 8'h33; a <= 8'h38; a++) begin
      u_host.rd(a[7:0], rd);
      chk("reg reset", rd, 0);
    end
    u_host.wr(8'h33, 8'hff);
    u_host.rd(8'h33, rd);
    chk("wake len", rd, 8'h07);
    u_host.wr(8'h34, 8'h3c);
    u_host.rd(8'h34, rd);
    chk("key hi", rd, 8'h3c);
    scan(0, 100);
    chk("touch", wheel_touched, 0);
    scan(0, 101);
    chk("touch", wheel_touched, 1);
    scan(0, 0);
    chk("touch", wheel_touched, 0);
    @(posedge clk) cfg.wheel_debounce_config <= 4'h5;
    scan(0, 200);
    chk("deb touch", wheel_touched, 0);
    scan(0, 200);
    chk("deb touch", wheel_touched, 1);
    scan(0, 0);
    chk("deb rel", wheel_touched, 1);
    scan(0, 0);
    chk("deb rel", wheel_touched, 0);
    @(posedge clk) cfg <= '{8'h00, 8'h02, 4'h0, 16'd100, 16'd3, 16'h0140};
    scan(0, 200);
    chk("stuck", wheel_touched, 1);
    repeat (5) scan(0, 200);
    chk("stuck", wheel_touched, 0);
    scan(0, 0);
    scan(0, 200);
    chk("stuck", wheel_touched, 1);
    @(posedge clk) cfg.hold_release_timeout <= 16'd0;
    scan(33, 200);
    chk("pos", wheel_position, 33);
    @(posedge clk) cfg.wheel_angle_shift <= 8'd64;
    scan(10, 200);
    chk("pos", wheel_position, 25);
    scan(50, 200);
    chk("pos", wheel_position, 5);
    @(posedge clk) cfg.wheel_angle_shift <= 8'd0;
    scan(10, 200);
    scan(11, 200);
    chk("slow", {rotate_cw, rotate_ccw}, 0);
    scan(14, 200);
    chk("cw", {rotate_cw, rotate_ccw}, 2);
    scan(10, 200);
    chk("ccw", {rotate_cw, rotate_ccw}, 1);
    u_host.wr(8'h37, 8'hf0);
    #1 chk("led7 cw", led7_on, 0);
    u_host.wr(8'h37, 8'he0);
    #1 chk("led7 ccw", led7_on, 1);
    scan(0, 0);
    @(posedge clk) wheel_ticks <= {50'h0, 10'h190};
    scan(0, 0);
    chk("hold", filter_hold, 1);
    chk("comp one", cs, 0);
    @(posedge clk) wheel_ticks <= {30'h0, {3{10'h190}}};
    scan(0, 0);
    chk("comp three", cs, 1);
    @(posedge clk) wheel_ticks <= {50'h0, 10'h338};
    scan(0, 0);
    chk("comp neg", cs, 1);
    chk("no hold", filter_hold, 0);
    @(posedge clk) wheel_ticks <= '0;
    scan(0, 0);
    u_host.wr(8'h37, 8'h70);
    wk(12'h080);
    chk("led7", led7_on, 1);
    wk(12'h000);
    u_host.wr(8'h33, 8'h00);
    @(posedge clk) doze <= 1'b1;
    w0 = wake_cnt;
    wk(12'h008);
    wk(12'h000);
    chk("wake any", wake_cnt != w0, 1);
    u_host.wr(8'h33, 8'h07);
    w0 = wake_cnt;
    wk(12'h008);
    wk(12'h000);
    chk("wake none", wake_cnt != w0, 0);
    @(posedge clk) wake_cmd <= 1'b1;
    @(posedge clk) wake_cmd <= 1'b0;
    repeat (3) @(posedge clk);
    chk("wake cmd", wake_cnt != w0, 1);
    w0 = wake_cnt;
    @(posedge clk) gen_in <= 1'b1;
    @(posedge clk) gen_in <= 1'b0;
    repeat (3) @(posedge clk);
    chk("wake input", wake_cnt != w0, 1);
    @(posedge clk) doze <= 1'b0;
    u_host.wr(8'h36, 8'hc5);
    u_host.wr(8'h33, 8'h02);
    @(posedge clk) doze <= 1'b1;
    w0 = wake_cnt;
    wk(12'h020);
    wk(12'h024);
    wk(12'h000);
    chk("wake seq", wake_cnt != w0, 0);
    scan(0, 200);
    scan(0, 0);
    repeat (3) @(posedge clk);
    chk("wake seq", wake_cnt != w0, 1);
    u_host.wr(8'h36, 8'h0d);
    u_host.wr(8'h33, 8'h01);
    w0 = wake_cnt;
    scan(20, 200);
    scan(20, 200);
    scan(10, 200);
    chk("wake ccw", wake_cnt != w0, 0);
    scan(10, 200);
    repeat (3) @(posedge clk);
    chk("wake ccw", wake_cnt != w0, 1);
    summarize;
  end
endmodule // tb
